// file: hw/drr_defs.vh
// Contract
// - Restore code 08 reloads defaults, resets drive
// - Restore refused while parameter lock set
// - Accel time spans 0Hz to max frequency
// - Decel time spans max frequency to 0Hz
// - Four ramp sets, 2-4 by terminals/program
// - Set 1 default; jog uses set 4
// - Reverse disabled ignores reverse commands
// - Stop key only for terminal/comm source; code also honours it for source 3
// - After stop key, run must re-assert
// - Mode 0 starts at start freq, optional brake
// - Mode 1 tracks downward from set frequency
// - Start braking skipped under tracking start
// - Mode 0 stop decelerates then coast or brake
// - Mode 1 stop cuts output, no braking
// - Start frequency 0.1-10.0Hz, default 0.5; code accepts any 7-bit value, 0.0-12.7Hz
// - Stop frequency 0.1-10.0Hz, default 0.5; code accepts any 7-bit value, 0.0-12.7Hz
// - Stop braking time 0.1s units, zero disables
// - Stop braking only in decelerating stop mode
// - Brake level 0.0-20.0%, default 2.0; code accepts any 8-bit value, 0.0-25.5%
// - Overcurrent during tracking lowers frequency first
// - Track time sets search; then accelerate
// - Source 1 terminals, 2 communication
`ifndef DRR_DEFS_VH
`define DRR_DEFS_VH

// Register byte offsets
`define DRR_OFF_CFG      8'h00
`define DRR_OFF_COMM     8'h04
`define DRR_OFF_RESTORE  8'h08
`define DRR_OFF_MAXF     8'h0C
`define DRR_OFF_SETF     8'h10
`define DRR_OFF_SSFREQ   8'h14
`define DRR_OFF_DCB      8'h18
`define DRR_OFF_TRACK    8'h1C
`define DRR_OFF_RAMP0    8'h20
`define DRR_OFF_STATUS   8'h40

// Configuration field positions
`define DRR_CFG_SRC_LO   0
`define DRR_CFG_REVOK    2
`define DRR_CFG_STOPKEY  3
`define DRR_CFG_STARTM   4
`define DRR_CFG_STOPM    5
`define DRR_CFG_LOCK     6
`define DRR_CFG_PSEL_LO  7
`define DRR_CFG_PEN      9

// Reset values
`define DRR_RST_CFG      10'h00C
`define DRR_RST_MAXF     16'h1388
`define DRR_RST_SETF     16'h0000
`define DRR_RST_JOGF     16'h01F4
`define DRR_RST_SSF      7'h05
`define DRR_RST_DCBT     8'h00
`define DRR_RST_DCBV     8'h14
`define DRR_RST_TRKT     8'h14
`define DRR_RST_TRKI     8'h96
`define DRR_RST_RAMP     16'h0032
`define DRR_RST_RESTORE  8'h00

// Restore command codes
`define DRR_RESTORE_CODE 8'h08
`define DRR_RESTORE_MAX  8'h0A

// Timing: ramp and brake unit is 0.1 s
`define DRR_UNIT_NS      100000000
`define DRR_CLK_NS       8
`define DRR_UNIT_CYC     (`DRR_UNIT_NS / `DRR_CLK_NS)

`endif

// file: hw/drr_ramp_ctrl.v
// The register addresses and the APB interface to the registers were chosen for this implementation.
`timescale 1ns/1ps
`include "drr_defs.vh"
module drr_ramp_ctrl #(
	parameter [39:0] UNIT_CYC = `DRR_UNIT_CYC
)(
	input  wire        clk,
	input  wire        rst_n,
	input  wire        ce,
	input  wire [7:0]  paddr,
	input  wire        psel,
	input  wire        penable,
	input  wire        pwrite,
	input  wire [31:0] pwdata,
	output reg  [31:0] prdata,
	output wire        pready,
	output wire        pslverr,
	input  wire        termFwd,
	input  wire        termRev,
	input  wire        termJog,
	input  wire [1:0]  termRampSel,
	input  wire        panelRun,
	input  wire        panelStop,
	input  wire [7:0]  outCurrentPct,
	output wire [15:0] outFreq,
	output wire        outReverse,
	output wire        outEnable,
	output wire        dcBrake,
	output wire [7:0]  dcBrakeLevel,
	output wire        tracking
);

	localparam [2:0] ST_IDLE  = 3'h0;
	localparam [2:0] ST_DCST  = 3'h1;
	localparam [2:0] ST_TRACK = 3'h2;
	localparam [2:0] ST_RUN   = 3'h3;
	localparam [2:0] ST_DECEL = 3'h4;
	localparam [2:0] ST_DCSP  = 3'h5;

	// Parameter registers
	reg  [9:0]  cfg_ff;
	reg  [1:0]  comm_ff;
	reg  [7:0]  restore_ff;
	reg  [15:0] maxF_ff;
	reg  [15:0] setF_ff;
	reg  [15:0] jogF_ff;
	reg  [6:0]  startF_ff;
	reg  [6:0]  stopF_ff;
	reg  [7:0]  dcbStartT_ff;
	reg  [7:0]  dcbStopT_ff;
	reg  [7:0]  dcbLevel_ff;
	reg  [7:0]  trkTime_ff;
	reg  [7:0]  trkCur_ff;
	reg  [15:0] accT_ff [0:3];
	reg  [15:0] decT_ff [0:3];

	// Drive state
	reg  [2:0]  state_ff;
	reg  [15:0] freq_ff;
	reg         rev_ff;
	reg         jog_ff;
	reg  [1:0]  set_ff;
	reg         panelLatch_ff;
	reg         stopLatch_ff;
	reg  [39:0] acc_ff;
	reg  [39:0] tick_ff;
	reg  [7:0]  units_ff;
	reg  [6:0]  syncA_ff;
	reg  [6:0]  syncB_ff;
	reg  [6:0]  pinPrev_ff;

	wire        wrEn;
	wire        rdEn;
	wire        mapped;
	wire        restoreNow;
	wire [1:0]  src;
	wire        sFwd;
	wire        sRev;
	wire        sJog;
	wire [1:0]  sSel;
	wire        runRise;
	wire        stopRise;
	wire        runRaw;
	wire        revReq;
	wire        runCmd;
	wire        runEff;
	wire        jogReq;
	wire [15:0] startF10;
	wire [15:0] stopF10;
	wire [15:0] tgtRaw;
	wire [15:0] tgt;
	wire [1:0]  selNow;
	reg  [15:0] rampT;
	wire [15:0] rampTEff;
	wire [39:0] rampLim;
	wire [39:0] accSum;
	wire        ramping;
	wire        stepNow;
	wire        unitTick;
	wire        overCur;
	wire        unitClr;
	wire [7:0]  unitsNow;

	// APB decode, zero wait states
	assign pready   = 1'b1;
	assign wrEn     = psel & penable & pwrite & ce;
	assign rdEn     = psel & ~penable & ~pwrite & ce;
	assign mapped   = (paddr[1:0] == 2'h0) && (paddr <= `DRR_OFF_STATUS);
	assign pslverr  = psel & penable & ~mapped;

	assign restoreNow = wrEn && (paddr == `DRR_OFF_RESTORE) && ~cfg_ff[`DRR_CFG_LOCK]
		&& (pwdata[7:0] == `DRR_RESTORE_CODE);

	// Pin synchronisers
	always @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			syncA_ff   <= 7'h00;
			syncB_ff   <= 7'h00;
			pinPrev_ff <= 7'h00;
		end
		else if (ce)
		begin
			syncA_ff   <= {panelStop, panelRun, termRampSel, termJog, termRev, termFwd};
			syncB_ff   <= syncA_ff;
			pinPrev_ff <= syncB_ff;
		end
	end

	assign sFwd     = syncB_ff[0];
	assign sRev     = syncB_ff[1];
	assign sJog     = syncB_ff[2];
	assign sSel     = syncB_ff[4:3];
	assign runRise  = syncB_ff[5] & ~pinPrev_ff[5];
	assign stopRise = syncB_ff[6] & ~pinPrev_ff[6];
	assign src      = cfg_ff[`DRR_CFG_SRC_LO+1:`DRR_CFG_SRC_LO];

	assign runRaw = (src == 2'h1) ? (sFwd | sRev) :
		(src == 2'h2) ? (comm_ff[0] | comm_ff[1]) : panelLatch_ff;
	assign revReq = (src == 2'h1) ? (sRev & ~sFwd) :
		(src == 2'h2) ? (comm_ff[1] & ~comm_ff[0]) : 1'b0;
	assign runCmd = runRaw & ~(revReq & ~cfg_ff[`DRR_CFG_REVOK]);
	assign runEff = runCmd & ~stopLatch_ff;
	assign jogReq = (src == 2'h1) & sJog;

	// Panel latch and stop-key latch
	always @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			panelLatch_ff <= 1'b0;
			stopLatch_ff  <= 1'b0;
		end
		else if (ce)
		begin
			if (stopRise)
				panelLatch_ff <= 1'b0;
			else if (runRise)
				panelLatch_ff <= 1'b1;
			// key honoured for sources 1, 2 and 3
			if (stopRise && (src != 2'h0) && cfg_ff[`DRR_CFG_STOPKEY] && runRaw)
				stopLatch_ff <= 1'b1;
			else if (!runRaw)
				stopLatch_ff <= 1'b0;
		end
	end

	// Scalar parameter registers
	always @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			cfg_ff       <= `DRR_RST_CFG;
			comm_ff      <= 2'h0;
			restore_ff   <= `DRR_RST_RESTORE;
			maxF_ff      <= `DRR_RST_MAXF;
			setF_ff      <= `DRR_RST_SETF;
			jogF_ff      <= `DRR_RST_JOGF;
			startF_ff    <= `DRR_RST_SSF;
			stopF_ff     <= `DRR_RST_SSF;
			dcbStartT_ff <= `DRR_RST_DCBT;
			dcbStopT_ff  <= `DRR_RST_DCBT;
			dcbLevel_ff  <= `DRR_RST_DCBV;
			trkTime_ff   <= `DRR_RST_TRKT;
			trkCur_ff    <= `DRR_RST_TRKI;
		end
		else if (ce && restoreNow)
		begin
			cfg_ff       <= `DRR_RST_CFG;
			comm_ff      <= 2'h0;
			restore_ff   <= `DRR_RST_RESTORE;
			maxF_ff      <= `DRR_RST_MAXF;
			setF_ff      <= `DRR_RST_SETF;
			jogF_ff      <= `DRR_RST_JOGF;
			startF_ff    <= `DRR_RST_SSF;
			stopF_ff     <= `DRR_RST_SSF;
			dcbStartT_ff <= `DRR_RST_DCBT;
			dcbStopT_ff  <= `DRR_RST_DCBT;
			dcbLevel_ff  <= `DRR_RST_DCBV;
			trkTime_ff   <= `DRR_RST_TRKT;
			trkCur_ff    <= `DRR_RST_TRKI;
		end
		else if (wrEn)
		begin
			case (paddr)
				`DRR_OFF_CFG:     cfg_ff <= pwdata[9:0];
				`DRR_OFF_COMM:    comm_ff <= pwdata[1:0];
				`DRR_OFF_RESTORE:
					if (pwdata[7:0] <= `DRR_RESTORE_MAX && pwdata[31:8] == 24'h000000)
						restore_ff <= pwdata[7:0];
				`DRR_OFF_MAXF:    maxF_ff <= pwdata[15:0];
				`DRR_OFF_SETF:
				begin
					setF_ff <= pwdata[15:0];
					jogF_ff <= pwdata[31:16];
				end
				`DRR_OFF_SSFREQ:
				begin
					startF_ff <= pwdata[6:0];
					stopF_ff  <= pwdata[14:8];
				end
				`DRR_OFF_DCB:
				begin
					dcbStartT_ff <= pwdata[7:0];
					dcbStopT_ff  <= pwdata[15:8];
					dcbLevel_ff  <= pwdata[23:16];
				end
				`DRR_OFF_TRACK:
				begin
					trkTime_ff <= pwdata[7:0];
					trkCur_ff  <= pwdata[15:8];
				end
				default: ;
			endcase
		end
	end

	genvar g;
	generate
		for (g = 0; g < 4; g = g + 1)
		begin : gRamp
			always @(posedge clk or negedge rst_n)
			begin
				if (!rst_n)
				begin
					accT_ff[g] <= `DRR_RST_RAMP;
					decT_ff[g] <= `DRR_RST_RAMP;
				end
				else if (ce && restoreNow)
				begin
					accT_ff[g] <= `DRR_RST_RAMP;
					decT_ff[g] <= `DRR_RST_RAMP;
				end
				else if (wrEn && paddr == `DRR_OFF_RAMP0 + 8 * g)
					accT_ff[g] <= pwdata[15:0];
				else if (wrEn && paddr == `DRR_OFF_RAMP0 + 8 * g + 4)
					decT_ff[g] <= pwdata[15:0];
			end
		end
	endgenerate

	// APB read data, captured in setup phase
	always @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
			prdata <= 32'h00000000;
		else if (rdEn)
		begin
			case (paddr)
				`DRR_OFF_CFG:     prdata <= {22'h000000, cfg_ff};
				`DRR_OFF_COMM:    prdata <= {30'h00000000, comm_ff};
				`DRR_OFF_RESTORE: prdata <= {24'h000000, restore_ff};
				`DRR_OFF_MAXF:    prdata <= {16'h0000, maxF_ff};
				`DRR_OFF_SETF:    prdata <= {jogF_ff, setF_ff};
				`DRR_OFF_SSFREQ:  prdata <= {17'h00000, stopF_ff, 1'b0, startF_ff};
				`DRR_OFF_DCB:     prdata <= {8'h00, dcbLevel_ff, dcbStopT_ff, dcbStartT_ff};
				`DRR_OFF_TRACK:   prdata <= {16'h0000, trkCur_ff, trkTime_ff};
				`DRR_OFF_STATUS:
					prdata <= {8'h00, stopLatch_ff, jog_ff, dcBrake, outEnable,
						rev_ff, state_ff, freq_ff};
				default:
					if (paddr >= `DRR_OFF_RAMP0 && paddr < `DRR_OFF_STATUS &&
						paddr[1:0] == 2'h0)
						prdata <= {16'h0000, paddr[2] ? decT_ff[paddr[4:3]] : accT_ff[paddr[4:3]]};
					else
						prdata <= 32'h00000000;
			endcase
		end
	end

	// Frequencies in 0.01 Hz
	assign startF10 = {9'h000, startF_ff} * 16'h000A;
	assign stopF10  = {9'h000, stopF_ff} * 16'h000A;
	assign tgtRaw   = jog_ff ? jogF_ff : setF_ff;
	assign tgt      = (tgtRaw > maxF_ff) ? maxF_ff : tgtRaw;

	// jog set 4, else default set 1
	assign selNow = jogReq ? 2'h3 : cfg_ff[`DRR_CFG_PEN] ?
		cfg_ff[`DRR_CFG_PSEL_LO+1:`DRR_CFG_PSEL_LO] : sSel;

	// Ramp time source
	always @*
	begin
		rampT = accT_ff[set_ff];
		if (state_ff == ST_TRACK)
			rampT = {8'h00, trkTime_ff};
		else if (state_ff == ST_DECEL || (state_ff == ST_RUN && freq_ff > tgt))
			rampT = decT_ff[set_ff];
	end

	assign rampTEff = (rampT == 16'h0000) ? 16'h0001 : rampT;
	assign rampLim  = {24'h000000, rampTEff} * UNIT_CYC;
	assign accSum   = acc_ff + {24'h000000, maxF_ff};
	assign ramping  = (state_ff == ST_TRACK) ||
		(state_ff == ST_RUN && freq_ff != tgt) ||
		(state_ff == ST_DECEL && freq_ff > stopF10);
	assign stepNow  = ramping && (accSum >= rampLim);
	assign unitTick = (tick_ff == UNIT_CYC - 40'h1);
	assign overCur  = outCurrentPct > trkCur_ff;
	// Unit timer restarts on entry to a timed state
	assign unitClr  = (state_ff == ST_IDLE) || (state_ff == ST_DECEL && freq_ff <= stopF10);
	// Counts the unit that ends on this edge
	assign unitsNow = units_ff + {7'h00, unitTick};

	// Step accumulator and 0.1 s tick
	always @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			acc_ff  <= 40'h0000000000;
			tick_ff <= 40'h0000000000;
		end
		else if (ce)
		begin
			acc_ff  <= !ramping ? 40'h0000000000 : stepNow ? accSum - rampLim : accSum;
			tick_ff <= (unitTick || unitClr) ? 40'h0000000000 : tick_ff + 40'h1;
		end
	end

	// Start, run and stop sequencer
	always @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			state_ff <= ST_IDLE;
			freq_ff  <= 16'h0000;
			rev_ff   <= 1'b0;
			jog_ff   <= 1'b0;
			set_ff   <= 2'h0;
			units_ff <= 8'h00;
		end
		else if (ce)
		begin
			if (unitTick)
				units_ff <= units_ff + 8'h01;
			if (!jog_ff)
				set_ff <= selNow;
			case (state_ff)
				ST_IDLE:
				begin
					freq_ff  <= 16'h0000;
					units_ff <= 8'h00;
					if (!restoreNow && (runEff || jogReq))
					begin
						jog_ff <= jogReq;
						set_ff <= selNow;
						rev_ff <= jogReq ? (sRev & cfg_ff[`DRR_CFG_REVOK]) : revReq;
						if (cfg_ff[`DRR_CFG_STARTM] && !jogReq)
						begin
							state_ff <= ST_TRACK;
							freq_ff  <= tgt;
						end
						else if (dcbStartT_ff != 8'h00)
							state_ff <= ST_DCST;
						else
						begin
							state_ff <= ST_RUN;
							freq_ff  <= startF10;
						end
					end
				end
				ST_DCST:
					if (unitsNow >= dcbStartT_ff)
					begin
						state_ff <= ST_RUN;
						freq_ff  <= startF10;
					end
				ST_TRACK:
				begin
					if (overCur && unitTick)
						units_ff <= units_ff;
					if (stepNow && freq_ff != 16'h0000)
						freq_ff <= freq_ff - 16'h0001;
					if (!overCur && (units_ff >= trkTime_ff || freq_ff <= startF10))
						state_ff <= ST_RUN;
				end
				ST_RUN:
					if (stepNow)
						freq_ff <= (freq_ff < tgt) ? freq_ff + 16'h0001 : freq_ff - 16'h0001;
				ST_DECEL:
					if (freq_ff <= stopF10)
					begin
						units_ff <= 8'h00;
						freq_ff  <= 16'h0000;
						state_ff <= (dcbStopT_ff != 8'h00) ? ST_DCSP : ST_IDLE;
					end
					else if (stepNow)
						freq_ff <= freq_ff - 16'h0001;
				ST_DCSP:
					if (unitsNow >= dcbStopT_ff)
						state_ff <= ST_IDLE;
				default:
					state_ff <= ST_IDLE;
			endcase
			// Jog release cuts output at once
			if (jog_ff && !jogReq && state_ff != ST_IDLE)
			begin
				state_ff <= ST_IDLE;
				freq_ff  <= 16'h0000;
				jog_ff   <= 1'b0;
			end
			else if (!jog_ff && !runEff && (state_ff == ST_RUN || state_ff == ST_TRACK ||
				state_ff == ST_DCST))
			begin
				if (cfg_ff[`DRR_CFG_STOPM] || state_ff == ST_DCST)
				begin
					state_ff <= ST_IDLE;
					freq_ff  <= 16'h0000;
				end
				// stop braking only in mode 0
				else
					state_ff <= ST_DECEL;
			end
			if (restoreNow)
			begin
				state_ff <= ST_IDLE;
				freq_ff  <= 16'h0000;
				jog_ff   <= 1'b0;
			end
			if (jog_ff && state_ff == ST_IDLE)
				jog_ff <= 1'b0;
		end
	end

	// Output decode
	assign outFreq      = freq_ff;
	assign outReverse   = rev_ff;
	assign outEnable    = (state_ff != ST_IDLE);
	assign dcBrake      = (state_ff == ST_DCST) || (state_ff == ST_DCSP);
	assign dcBrakeLevel = dcBrake ? dcbLevel_ff : 8'h00;
	assign tracking     = (state_ff == ST_TRACK);

endmodule

// file: testbench/drr_pin_model.sv
`timescale 1ns/1ps
// Operator side: terminal levels and panel stop key
module drr_pin_model (
	input  wire       clk,
	input  wire       rst_n,
	input  wire       wantFwd,
	input  wire       wantRev,
	input  wire       wantJog,
	input  wire [1:0] wantSel,
	input  wire       keyStop,
	output reg        termFwd,
	output reg        termRev,
	output reg        termJog,
	output reg  [1:0] termRampSel,
	output wire       panelRun,
	output wire       panelStop
);
	reg [2:0] keyCnt_ff;

	// Run key unused; stop key held long enough for the synchroniser
	assign panelRun = 1'b0;
	assign panelStop = |keyCnt_ff;

	// Pins follow the operator's requests one cycle later
	always @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			{termFwd, termRev, termJog, termRampSel} <= 5'h00;
			keyCnt_ff <= 3'h0;
		end
		else
		begin
			{termFwd, termRev, termJog, termRampSel} <= {wantFwd, wantRev, wantJog, wantSel};
			keyCnt_ff <= keyStop ? 3'h7 : keyCnt_ff - {2'h0, |keyCnt_ff};
		end
	end
endmodule

// file: testbench/drr_ramp_ctrl_chk.sv
`timescale 1ns/1ps
`include "drr_defs.vh"
module drr_ramp_chk #(
	parameter [39:0] UNIT_CYC = `DRR_UNIT_CYC
)(
	input wire        clk,
	input wire        rst_n,
	input wire        ce,
	input wire [7:0]  paddr,
	input wire        psel,
	input wire        penable,
	input wire        pwrite,
	input wire [31:0] pwdata,
	input wire [31:0] prdata,
	input wire        pready,
	input wire        pslverr,
	input wire        termFwd,
	input wire        termRev,
	input wire        termJog,
	input wire [1:0]  termRampSel,
	input wire        panelRun,
	input wire        panelStop,
	input wire [7:0]  outCurrentPct,
	input wire [15:0] outFreq,
	input wire        outReverse,
	input wire        outEnable,
	input wire        dcBrake,
	input wire [7:0]  dcBrakeLevel,
	input wire        tracking
);
	reg  [9:0] cfg_ff;
	wire       wrHit;
	wire       termStop;

	// Shadow of the configuration word, reloaded by a restore
	assign wrHit = psel && penable && pwrite && ce;
	always @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
			cfg_ff <= `DRR_RST_CFG;
		else if (wrHit && paddr == `DRR_OFF_CFG)
			cfg_ff <= pwdata[9:0];
		else if (wrHit && paddr == `DRR_OFF_RESTORE && pwdata[7:0] == 8'h08 && !cfg_ff[6])
			cfg_ff <= `DRR_RST_CFG;
	end

	// Forward terminal stop while running plainly
	assign termStop = cfg_ff[1:0] == 2'h1 && !termRev && !termJog && !dcBrake && !tracking;

	default clocking cb @(posedge clk);
	endclocking
	default disable iff (!rst_n);

	AST_SLVERR: assert property (psel && penable && paddr > 8'h40 |-> pslverr)
		else $error("unmapped access not flagged");
	AST_OFF_ZERO: assert property (!outEnable |-> outFreq == 16'h0000)
		else $error("frequency while output off");
	AST_TRACK_NOBRK: assert property (tracking |-> !dcBrake && outEnable)
		else $error("brake during tracking");
	AST_BRK_LEVEL: assert property (!dcBrake |-> dcBrakeLevel == 8'h00)
		else $error("brake level outside braking");
	AST_RAMP_STEP: assert property ($past(outEnable) && !$past(dcBrake) && !$past(tracking)
		&& outEnable && !dcBrake && !tracking |-> $stable(outFreq)
		|| outFreq - $past(outFreq) == 16'h0001 || $past(outFreq) - outFreq == 16'h0001)
		else $error("ramp step above one");
	AST_REV_BLOCK: assert property ($rose(outEnable) && !cfg_ff[2] |-> ##1 !outReverse)
		else $error("reverse while disallowed");
	AST_STOP_CUT: assert property (cfg_ff[5] && termStop && $fell(termFwd) && outEnable
		|-> ##[1:5] !outEnable)
		else $error("coast stop not immediate");
	AST_DECEL: assert property (!cfg_ff[5] && termStop && $fell(termFwd) && outFreq > 16'h0080
		|-> ##6 outEnable)
		else $error("decelerating stop cut early");

	COV_TRACK: cover property (tracking);
	COV_BRAKE: cover property ($fell(dcBrake));
	COV_STOP: cover property ($fell(outEnable));
endmodule

bind drr_ramp_ctrl drr_ramp_chk #(.UNIT_CYC(UNIT_CYC)) i_chk (
	.clk(clk), .rst_n(rst_n), .ce(ce), .paddr(paddr), .psel(psel), .penable(penable),
	.pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
	.termFwd(termFwd), .termRev(termRev), .termJog(termJog), .termRampSel(termRampSel),
	.panelRun(panelRun), .panelStop(panelStop), .outCurrentPct(outCurrentPct),
	.outFreq(outFreq), .outReverse(outReverse), .outEnable(outEnable), .dcBrake(dcBrake),
	.dcBrakeLevel(dcBrakeLevel), .tracking(tracking)
);

// file: testbench/drr_ramp_ctrl_bench.sv
`timescale 1ns/1ps
module drr_ramp_ctrl_bench;
	logic        clk = 1'b0;
	logic        rst_n = 1'b0;
	logic        ce = 1'b1;
	logic [7:0]  paddr = 8'h00;
	logic        psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
	logic [31:0] pwdata = 32'h00000000;
	wire  [31:0] prdata;
	wire         pready, pslverr, termFwd, termRev, termJog, panelRun, panelStop;
	wire  [1:0]  termRampSel;
	logic        wantFwd = 1'b0, wantRev = 1'b0, wantJog = 1'b0, keyStop = 1'b0;
	logic [1:0]  wantSel = 2'h0;
	logic [7:0]  outCurrentPct = 8'h00;
	wire  [15:0] outFreq;
	wire  [7:0]  dcBrakeLevel;
	wire         outReverse, outEnable, dcBrake, tracking;
	int          badCount = 0, nChecks = 0, n;
	logic [31:0] r;
	logic        e;
	logic [15:0] fPrev;
	logic [7:0]  ra [6] = '{8'h00, 8'h14, 8'h18, 8'h1C, 8'h20, 8'h0C};
	logic [31:0] rv [6] = '{32'h0000000C, 32'h00000505, 32'h00140000, 32'h00009614,
		32'h00000032, 32'h00001388};
	logic [7:0]  wa [7] = '{8'h20, 8'h24, 8'h28, 8'h38, 8'h10, 8'h18, 8'h1C};
	logic [31:0] wv [7] = '{32'h000001F4, 32'h000000FA, 32'h000003E8, 32'h000000FA,
		32'h0BB80FA0, 32'h00140302, 32'h00006414};

	drr_ramp_ctrl #(.UNIT_CYC(40'h0000000014)) i_dut (
		.clk(clk), .rst_n(rst_n), .ce(ce), .paddr(paddr), .psel(psel), .penable(penable),
		.pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
		.termFwd(termFwd), .termRev(termRev), .termJog(termJog), .termRampSel(termRampSel),
		.panelRun(panelRun), .panelStop(panelStop), .outCurrentPct(outCurrentPct),
		.outFreq(outFreq), .outReverse(outReverse), .outEnable(outEnable), .dcBrake(dcBrake),
		.dcBrakeLevel(dcBrakeLevel), .tracking(tracking)
	);
	drr_pin_model i_pins (
		.clk(clk), .rst_n(rst_n), .wantFwd(wantFwd), .wantRev(wantRev), .wantJog(wantJog),
		.wantSel(wantSel), .keyStop(keyStop), .termFwd(termFwd), .termRev(termRev),
		.termJog(termJog), .termRampSel(termRampSel), .panelRun(panelRun), .panelStop(panelStop)
	);

	// Free-running 125 MHz clock
	always #4 clk = ~clk;

	task automatic closeOut;
		$display("checks %0d mismatches %0d", nChecks, badCount);
		if (badCount == 0 && nChecks > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask

	task automatic chk(input string nm, input logic [31:0] x, input logic [31:0] g);
		nChecks++;
		if (g !== x)
		begin
			badCount++;
			$display("[ERR] %s exp %0h got %0h", nm, x, g);
		end
	endtask

	// One APB transfer; entered just after a rising edge
	task automatic apb(input logic [7:0] a, input logic w, input logic [31:0] d);
		int k;
		psel <= 1'b1;
		paddr <= a;
		pwrite <= w;
		pwdata <= d;
		@(posedge clk);
		penable <= 1'b1;
		k = 0;
		do
		begin
			@(posedge clk);
			k++;
		end
		while (pready !== 1'b1 && k < 20);
		r = prdata;
		e = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge clk);
		chk("pready", 1, k < 20);
		if (k >= 20)
			closeOut;
	endtask

	function automatic logic sig(input int s);
		return s == 0 ? outEnable : (s == 1 ? dcBrake : tracking);
	endfunction

	// Counts falling edges until the chosen output reaches v
	task automatic waitv(input int s, input logic v);
		n = 0;
		do
		begin
			fPrev = outFreq;
			@(negedge clk);
			n++;
			if (n > 5000)
			begin
				badCount++;
				closeOut;
			end
		end
		while (sig(s) !== v);
		@(posedge clk);
	endtask

	task automatic slope(input string nm, input int x);
		int d;
		d = outFreq;
		repeat (200) @(negedge clk);
		d = int'(outFreq) - d;
		chk(nm, x, (d >= x - 3 && d <= x + 3) ? x : d);
		@(posedge clk);
	endtask

	initial
	begin
		repeat (3) @(posedge clk);
		rst_n <= 1'b1;
		@(posedge clk);
		// Reset values and an unmapped word
		foreach (ra[i])
		begin
			apb(ra[i], 1'b0, 32'h00000000);
			chk("reg", rv[i], r);
		end
		apb(8'h44, 1'b0, 32'h00000000);
		chk("slverr", 1, e);
		chk("unmapped", 0, r);
		$display("test regs done");
		// Restore refused while locked, out of range ignored
		apb(8'h00, 1'b1, 32'h0000004D);
		apb(8'h08, 1'b1, 32'h00000008);
		apb(8'h00, 1'b0, 32'h00000000);
		chk("locked", 32'h0000004D, r);
		apb(8'h08, 1'b1, 32'h0000000B);
		apb(8'h08, 1'b0, 32'h00000000);
		chk("range", 32'h00000008, r);
		apb(8'h00, 1'b1, 32'h0000000D);
		apb(8'h08, 1'b1, 32'h00000008);
		apb(8'h00, 1'b0, 32'h00000000);
		chk("restored", 32'h0000000C, r);
		apb(8'h08, 1'b0, 32'h00000000);
		chk("rstcode", 32'h00000000, r);
		$display("test restore done");
		// Ramp sets, brake times, tracking current of 100 percent
		foreach (wa[i])
			apb(wa[i], 1'b1, wv[i]);
		apb(8'h00, 1'b1, 32'h0000000D);
		wantFwd <= 1'b1;
		waitv(1, 1'b1);
		chk("level", 8'h14, dcBrakeLevel);
		waitv(1, 1'b0);
		chk("dcstart", 40, n);
		chk("f0", 50, outFreq);
		slope("acc1", 100);
		wantSel <= 2'h1;
		slope("acc2", 50);
		wantSel <= 2'h0;
		wantFwd <= 1'b0;
		waitv(1, 1'b1);
		chk("fstop", 50, fPrev);
		waitv(1, 1'b0);
		chk("dcstop", 60, n);
		$display("test start stop done");
		// Coasting stop: no ramp, no brake
		apb(8'h00, 1'b1, 32'h0000002D);
		wantFwd <= 1'b1;
		waitv(1, 1'b1);
		waitv(1, 1'b0);
		repeat (40) @(posedge clk);
		wantFwd <= 1'b0;
		waitv(0, 1'b0);
		chk("coast", 1, n < 7);
		repeat (5) @(negedge clk);
		chk("nobrk", 0, dcBrake);
		$display("test coast done");
		// Tracking start, held by overcurrent
		apb(8'h00, 1'b1, 32'h0000001D);
		wantFwd <= 1'b1;
		waitv(2, 1'b1);
		chk("trbrk", 0, dcBrake);
		chk("trf", 1, outFreq <= 16'h0FA0);
		outCurrentPct <= 8'hC8;
		repeat (450) @(posedge clk);
		chk("oc", 1, tracking);
		outCurrentPct <= 8'h00;
		waitv(2, 1'b0);
		chk("run", 1, outEnable);
		wantFwd <= 1'b0;
		waitv(0, 1'b0);
		$display("test track done");
		// Reverse inhibit
		apb(8'h00, 1'b1, 32'h00000009);
		wantRev <= 1'b1;
		repeat (20) @(negedge clk);
		chk("revoff", 0, outEnable);
		@(posedge clk);
		wantRev <= 1'b0;
		wantFwd <= 1'b1;
		waitv(0, 1'b1);
		wantFwd <= 1'b0;
		waitv(0, 1'b0);
		apb(8'h00, 1'b1, 32'h0000000D);
		wantRev <= 1'b1;
		waitv(0, 1'b1);
		repeat (2) @(negedge clk);
		chk("reven", 1, outReverse);
		@(posedge clk);
		wantRev <= 1'b0;
		waitv(0, 1'b0);
		$display("test reverse done");
		// Stop key, then run must be re-asserted
		wantFwd <= 1'b1;
		waitv(0, 1'b1);
		keyStop <= 1'b1;
		@(posedge clk);
		keyStop <= 1'b0;
		waitv(0, 1'b0);
		repeat (50) @(negedge clk);
		chk("relatch", 0, outEnable);
		@(posedge clk);
		wantFwd <= 1'b0;
		repeat (6) @(posedge clk);
		wantFwd <= 1'b1;
		waitv(0, 1'b1);
		apb(8'h00, 1'b1, 32'h00000005);
		keyStop <= 1'b1;
		@(posedge clk);
		keyStop <= 1'b0;
		repeat (50) @(negedge clk);
		chk("keyoff", 1, outEnable);
		@(posedge clk);
		wantFwd <= 1'b0;
		waitv(0, 1'b0);
		$display("test stop key done");
		// Jog uses set 4 and stops at once
		wantJog <= 1'b1;
		waitv(0, 1'b1);
		waitv(1, 1'b0);
		slope("jog", 200);
		wantJog <= 1'b0;
		waitv(0, 1'b0);
		chk("jogoff", 1, n < 7);
		$display("test jog done");
		// Communication source, program ramp set 2, stop key hold-off
		apb(8'h00, 1'b1, 32'h0000028E);
		apb(8'h04, 1'b1, 32'h00000001);
		waitv(1, 1'b1);
		waitv(1, 1'b0);
		slope("prog", 50);
		keyStop <= 1'b1;
		@(posedge clk);
		keyStop <= 1'b0;
		waitv(0, 1'b0);
		repeat (50) @(negedge clk);
		chk("commhold", 0, outEnable);
		@(posedge clk);
		apb(8'h04, 1'b1, 32'h00000000);
		apb(8'h04, 1'b1, 32'h00000001);
		waitv(0, 1'b1);
		apb(8'h04, 1'b1, 32'h00000000);
		waitv(0, 1'b0);
		$display("test comm done");
		closeOut;
	end
endmodule
